// ==== citd_cnt.v ====
// down counter for the cycles of one instruction
`timescale 1ns/1ps
module citd_cnt #(
   parameter W = 4
) (
   input wire mclk,            // system clock
   input wire sys_rst,         // synchronous reset
   input wire load,            // load a new count
   input wire [W-1:0] load_val, // count to load
   input wire dec,             // count down one
   output reg [W-1:0] cnt_ff,  // cycles left
   output wire last            // one cycle left
);
   reg [W-1:0] nxt_cnt;

   assign last = (cnt_ff == {{(W-1){1'b0}}, 1'b1});

   always @* begin
      nxt_cnt = cnt_ff;
      if (load) begin
         nxt_cnt = load_val;
      end else if (dec && (cnt_ff != {W{1'b0}})) begin
         nxt_cnt = cnt_ff - {{(W-1){1'b0}}, 1'b1};
      end
   end

   always @(posedge mclk) begin
      if (sys_rst) begin
         cnt_ff <= {W{1'b0}};
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end
endmodule // citd_cnt

// ==== citd_decoder.v ====
// instruction length, cycle timing and operand decode for the core
`timescale 1ns/1ps
`include "citd_defines.vh"
// Contract
// - external move reaches ram, off-chip, flash
// - external interface carries off-chip external moves
// - arithmetic register form: one byte, 1 cycle
// - arithmetic direct/immediate: two bytes, 2 cycles
// - arithmetic indirect: one byte, 2 cycles
// - increment/decrement timing by operand form
// - data pointer increment: one byte, 1 cycle
// - multiply: one byte, 4 cycles
// - divide: one byte, 8 cycles
// - logic into accumulator: 1 or 2 cycles
// - logic into direct byte: 2 or 3
// - accumulator-only operations: one byte, 1 cycle
// - register/accumulator loads: 1 or 2 cycles
// - moves into direct byte: 2 or 3
// - indirect ram moves take 2 cycles
// - wide immediate pointer load: three bytes, 3
// - code byte reads: one byte, 3 cycles
// - external moves: one byte, 3, 8/16-bit address
// - push and pop: two bytes, 2 cycles
// - accumulator exchange timing by operand form
// - low nibble exchange: bits 3:0, 2 cycles
// - working register picks one of eight in bank
// - indirect address from register zero or one
// - direct below 0x80 ram, above special registers
module citd_decoder #(
   parameter EMIF_PRESENT = 1,
   parameter [16:0] EXT_RAM_BYTES = `CITD_EXT_RAM_BYTES
) (
   input wire mclk,              // system clock
   input wire sys_rst,           // synchronous reset, active high
   input wire op_valid,          // opcode offered
   input wire [7:0] opcode,      // first instruction byte
   output wire op_ready,         // opcode taken this cycle when valid
   input wire [1:0] bank_sel,    // selected register bank
   input wire [7:0] r0_value,    // working register zero contents
   input wire [7:0] r1_value,    // working register one contents
   input wire [7:0] xpage,       // high address byte for 8-bit external moves
   input wire [15:0] data_pointer, // data pointer contents
   input wire flash_access_en,   // external moves address program flash
   input wire [7:0] direct_addr, // direct address byte of the instruction
   output wire busy,             // instruction executing
   output wire op_done,          // last cycle of the instruction
   output reg [1:0] op_bytes_ff,  // instruction length in bytes
   output reg [3:0] op_cycles_ff, // instruction time in cycles
   output reg [3:0] op_kind_ff,   // instruction kind
   output reg op_legal_ff,        // opcode is in the decoded set
   output reg use_work_reg_ff,    // working register operand
   output reg [4:0] work_reg_addr_ff, // ram address of working register
   output reg use_indirect_ff,    // indirect ram operand
   output reg [7:0] indirect_addr_ff, // ram address of indirect operand
   output reg use_direct_ff,      // direct address operand
   output reg direct_sfr_ff,      // direct address hits special registers
   output reg xmove_ff,           // external-data move
   output reg xmove_write_ff,     // external move writes memory
   output reg xmove_wide_ff,      // 16-bit address form
   output reg [15:0] xaddr_ff,    // external move address
   output reg [2:0] xtarget_ff,   // external move target, one-hot
   output reg emif_req_ff,        // one-cycle request to external interface
   output reg [7:0] xchg_mask_ff  // accumulator bits swapped by exchange
);
   // ************************************************************
   // states
   // ************************************************************
   localparam [1:0] ST_IDLE = 2'b01;
   localparam [1:0] ST_EXEC = 2'b10;

   reg [1:0] state_ff;
   reg [1:0] nxt_state;
   reg [5:0] d_bc;
   reg [3:0] d_kind;
   reg d_legal, d_wreg, d_ri, d_dir, d_xwr, d_xwide, d_nib;
   wire [3:0] hi;
   wire [3:0] lo;
   wire ri_form, col_imm_dir, take, cnt_last;
   wire [7:0] ri_val;
   wire [15:0] x_addr;
   wire [2:0] x_tgt;

   assign hi = opcode[7:4];
   assign lo = opcode[3:0];
   assign ri_form = (opcode[3:1] == 3'h3);
   assign col_imm_dir = (lo == 4'h4) || (lo == 4'h5);

   // ************************************************************
   // opcode table
   // ************************************************************
   always @* begin
      d_bc = {`CITD_LEN_1, `CITD_CYC_1};
      d_kind = `CITD_K_NONE;
      d_legal = 1'b1;
      d_wreg = opcode[3];
      d_ri = ri_form;
      d_dir = 1'b0;
      d_xwr = 1'b0;
      d_xwide = 1'b0;
      d_nib = 1'b0;
      if (((hi == 4'h2) || (hi == 4'h3) || (hi == 4'h9)) && (lo >= 4'h4)) begin
         d_kind = `CITD_K_ARITH;
         d_dir = (lo == 4'h5);
         if (col_imm_dir) begin
            d_bc = {`CITD_LEN_2, `CITD_CYC_2};
         end else if (ri_form) begin
            d_bc = {`CITD_LEN_1, `CITD_CYC_2};
         end else begin
            d_bc = {`CITD_LEN_1, `CITD_CYC_1};
         end
      end else if ((hi >= 4'h4) && (hi <= 4'h6) && (lo >= 4'h2)) begin
         d_kind = `CITD_K_LOGIC;
         d_dir = (lo == 4'h2) || (lo == 4'h3) || (lo == 4'h5);
         if (lo == 4'h2) begin
            d_bc = {`CITD_LEN_2, `CITD_CYC_2};
         end else if (lo == 4'h3) begin
            d_bc = {`CITD_LEN_3, `CITD_CYC_3};
         end else if (col_imm_dir) begin
            d_bc = {`CITD_LEN_2, `CITD_CYC_2};
         end else if (ri_form) begin
            d_bc = {`CITD_LEN_1, `CITD_CYC_2};
         end else begin
            d_bc = {`CITD_LEN_1, `CITD_CYC_1};
         end
      end else if ((hi <= 4'h1) && (lo >= 4'h4)) begin
         d_kind = `CITD_K_INCDEC;
         d_dir = (lo == 4'h5);
         if (lo == 4'h5) begin
            d_bc = {`CITD_LEN_2, `CITD_CYC_2};
         end else if (ri_form) begin
            d_bc = {`CITD_LEN_1, `CITD_CYC_2};
         end else begin
            d_bc = {`CITD_LEN_1, `CITD_CYC_1};
         end
      end else begin
         casez (opcode)
            8'hA3: begin
               d_kind = `CITD_K_DPINC;
               d_bc = {`CITD_LEN_1, `CITD_CYC_1};
            end
            8'hA4: begin
               d_kind = `CITD_K_MUL;
               d_bc = {`CITD_LEN_1, `CITD_CYC_4};
            end
            8'h84: begin
               d_kind = `CITD_K_DIV;
               d_bc = {`CITD_LEN_1, `CITD_CYC_8};
            end
            8'hD4, 8'hE4, 8'hF4, 8'h03, 8'h13, 8'h23, 8'h33, 8'hC4: begin
               d_kind = `CITD_K_ACCU;
               d_bc = {`CITD_LEN_1, `CITD_CYC_1};
            end
            8'b1110_1???, 8'b1111_1???: begin
               d_kind = `CITD_K_MOV;
               d_bc = {`CITD_LEN_1, `CITD_CYC_1};
            end
            8'hE5, 8'h74, 8'b0111_1???: begin
               d_kind = `CITD_K_MOV;
               d_dir = (opcode == 8'hE5);
               d_bc = {`CITD_LEN_2, `CITD_CYC_2};
            end
            8'b1010_1???, 8'hF5, 8'b1000_1???, 8'b1000_011?: begin
               d_kind = `CITD_K_MOV;
               d_dir = 1'b1;
               d_bc = {`CITD_LEN_2, `CITD_CYC_2};
            end
            8'h85, 8'h75, 8'h90: begin
               d_kind = `CITD_K_MOV;
               d_dir = (opcode != 8'h90);
               d_bc = {`CITD_LEN_3, `CITD_CYC_3};
            end
            8'b1110_011?, 8'b1111_011?: begin
               d_kind = `CITD_K_MOV;
               d_bc = {`CITD_LEN_1, `CITD_CYC_2};
            end
            8'b1010_011?, 8'b0111_011?: begin
               d_kind = `CITD_K_MOV;
               d_dir = opcode[7];
               d_bc = {`CITD_LEN_2, `CITD_CYC_2};
            end
            8'h93, 8'h83: begin
               d_kind = `CITD_K_CODE;
               d_bc = {`CITD_LEN_1, `CITD_CYC_3};
            end
            8'b1110_001?, 8'b1111_001?, 8'hE0, 8'hF0: begin
               d_kind = `CITD_K_XMOVE;
               d_ri = (opcode[3:1] == 3'h1);
               d_xwr = opcode[4];
               d_xwide = (opcode[3:0] == 4'h0);
               d_bc = {`CITD_LEN_1, `CITD_CYC_3};
            end
            8'hC0, 8'hD0: begin
               d_kind = `CITD_K_STACK;
               d_dir = 1'b1;
               d_bc = {`CITD_LEN_2, `CITD_CYC_2};
            end
            8'b1100_1???: begin
               d_kind = `CITD_K_ACC_EXCH;
               d_bc = {`CITD_LEN_1, `CITD_CYC_1};
            end
            8'hC5: begin
               d_kind = `CITD_K_ACC_EXCH;
               d_dir = 1'b1;
               d_bc = {`CITD_LEN_2, `CITD_CYC_2};
            end
            8'b1100_011?: begin
               d_kind = `CITD_K_ACC_EXCH;
               d_bc = {`CITD_LEN_1, `CITD_CYC_2};
            end
            8'b1101_011?: begin
               d_kind = `CITD_K_NIBX;
               d_nib = 1'b1;
               d_bc = {`CITD_LEN_1, `CITD_CYC_2};
            end
            default: begin
               d_legal = 1'b0;
               d_wreg = 1'b0;
               d_ri = 1'b0;
            end
         endcase
      end
   end

   // ************************************************************
   // execution sequencing
   // ************************************************************
   assign busy = (state_ff == ST_EXEC);
   assign op_done = busy && cnt_last;
   assign op_ready = !busy || op_done;
   assign take = op_valid && op_ready;

   citd_cnt #(
      .W(4)
   ) u_cnt (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .load(take),
      .load_val(d_bc[3:0]),
      .dec(busy),
      .cnt_ff(),
      .last(cnt_last)
   );

   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (take) begin
               nxt_state = ST_EXEC;
            end
         end
         ST_EXEC: begin
            if (cnt_last && !take) begin
               nxt_state = ST_IDLE;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   // ************************************************************
   // external-data move target
   // ************************************************************
   assign ri_val = opcode[0] ? r1_value : r0_value;

   citd_xtgt #(
      .EMIF_PRESENT(EMIF_PRESENT),
      .EXT_RAM_BYTES(EXT_RAM_BYTES)
   ) u_xtgt (
      .wide(d_xwide),
      .ri_val(ri_val),
      .xpage(xpage),
      .data_pointer(data_pointer),
      .flash_access_en(flash_access_en),
      .xaddr(x_addr),
      .target(x_tgt)
   );

   // ************************************************************
   // decoded outputs
   // ************************************************************
   always @(posedge mclk) begin
      if (sys_rst) begin
         state_ff <= ST_IDLE;
         op_bytes_ff <= 2'h0;
         op_cycles_ff <= 4'h0;
         op_kind_ff <= `CITD_K_NONE;
         op_legal_ff <= 1'b0;
         use_work_reg_ff <= 1'b0;
         work_reg_addr_ff <= 5'h00;
         use_indirect_ff <= 1'b0;
         indirect_addr_ff <= 8'h00;
         use_direct_ff <= 1'b0;
         direct_sfr_ff <= 1'b0;
         xmove_ff <= 1'b0;
         xmove_write_ff <= 1'b0;
         xmove_wide_ff <= 1'b0;
         xaddr_ff <= 16'h0000;
         xtarget_ff <= `CITD_TGT_NONE;
         emif_req_ff <= 1'b0;
         xchg_mask_ff <= `CITD_MASK_FULL;
      end else begin
         state_ff <= nxt_state;
         direct_sfr_ff <= (direct_addr >= `CITD_SFR_BASE);
         emif_req_ff <= take && (d_kind == `CITD_K_XMOVE) &&
                        (x_tgt == `CITD_TGT_EMIF);
         if (take) begin
            op_bytes_ff <= d_bc[5:4];
            op_cycles_ff <= d_bc[3:0];
            op_kind_ff <= d_kind;
            op_legal_ff <= d_legal;
            use_work_reg_ff <= d_wreg;
            work_reg_addr_ff <= {bank_sel, opcode[2:0]};
            use_indirect_ff <= d_ri && (d_kind != `CITD_K_XMOVE);
            indirect_addr_ff <= ri_val;
            use_direct_ff <= d_dir;
            xmove_ff <= (d_kind == `CITD_K_XMOVE);
            xmove_write_ff <= d_xwr;
            xmove_wide_ff <= d_xwide;
            if (d_kind == `CITD_K_XMOVE) begin
               xaddr_ff <= x_addr;
               xtarget_ff <= x_tgt;
            end else begin
               xaddr_ff <= 16'h0000;
               xtarget_ff <= `CITD_TGT_NONE;
            end
            xchg_mask_ff <= d_nib ? `CITD_MASK_LOW : `CITD_MASK_FULL;
         end
      end
   end
endmodule // citd_decoder

// ==== citd_decoder_asserts.sv ====
// concurrent checks on the ports of the instruction timing decoder
`timescale 1ns/1ps
`include "citd_defines.vh"
module citd_asserts (
   input logic mclk, // clock
   input logic sys_rst, // reset
   input logic op_valid, // offer
   input logic [7:0] opcode, // first byte
   input logic op_ready, // taken
   input logic [1:0] bank_sel, // bank
   input logic [7:0] r0_value, // reg zero
   input logic [7:0] r1_value, // reg one
   input logic [7:0] xpage, // high address
   input logic flash_access_en, // flash mode
   input logic [7:0] direct_addr, // direct byte
   input logic busy, // executing
   input logic op_done, // last cycle
   input logic [1:0] op_bytes_ff, // length
   input logic [3:0] op_cycles_ff, // time
   input logic use_work_reg_ff, // reg operand
   input logic [4:0] work_reg_addr_ff, // reg address
   input logic use_indirect_ff, // indirect operand
   input logic [7:0] indirect_addr_ff, // indirect address
   input logic direct_sfr_ff, // sfr hit
   input logic xmove_ff, // external move
   input logic xmove_wide_ff, // wide form
   input logic [15:0] xaddr_ff, // move address
   input logic [2:0] xtarget_ff, // move target
   input logic emif_req_ff, // interface request
   input logic [7:0] xchg_mask_ff // swap mask
);
// ********
// assertions
// ********
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);
   wire take = op_valid && op_ready;
   property p_mul;
      take && opcode == 8'hA4 |=> (op_cycles_ff == 4'h4 && !op_done) [*3] ##1 op_done;
   endproperty
   a_mul: assert property (p_mul) else $error("multiply timing wrong");
   property p_div;
      take && opcode == 8'h84 |=> (!op_done) [*7] ##1 (op_done && op_bytes_ff == 2'h1);
   endproperty
   a_div: assert property (p_div) else $error("divide timing wrong");
   property p_one;
      take && opcode[7:3] == 5'h05 |=> op_done && op_cycles_ff == 4'h1 && op_bytes_ff == 2'h1;
   endproperty
   a_one: assert property (p_one) else $error("register add timing wrong");
   property p_x8;
      take && opcode inside {8'hE2, 8'hE3, 8'hF2, 8'hF3} |=> xmove_ff && !xmove_wide_ff
         && xaddr_ff == {$past(xpage), $past(opcode[0]) ? $past(r1_value) : $past(r0_value)};
   endproperty
   a_x8: assert property (p_x8) else $error("narrow move address wrong");
   property p_emif;
      emif_req_ff |-> (xmove_ff && xtarget_ff == `CITD_TGT_EMIF) ##1 !emif_req_ff;
   endproperty
   a_emif: assert property (p_emif) else $error("interface request wrong");
   property p_flash;
      take && flash_access_en && opcode inside {8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3}
         |=> xtarget_ff == `CITD_TGT_FLASH;
   endproperty
   a_flash: assert property (p_flash) else $error("flash target missed");
   property p_work;
      take && opcode[7:3] == 5'h01 |=> use_work_reg_ff
         && work_reg_addr_ff == {$past(bank_sel), $past(opcode[2:0])};
   endproperty
   a_work: assert property (p_work) else $error("register address wrong");
   property p_ind;
      take && opcode inside {8'h26, 8'h27} |=> use_indirect_ff
         && indirect_addr_ff == ($past(opcode[0]) ? $past(r1_value) : $past(r0_value));
   endproperty
   a_ind: assert property (p_ind) else $error("indirect address wrong");
   property p_sfr;
      !sys_rst |=> direct_sfr_ff == $past(direct_addr[7]);
   endproperty
   a_sfr: assert property (p_sfr) else $error("direct space split wrong");
   property p_nib;
      take && opcode inside {8'hD6, 8'hD7} |=> xchg_mask_ff == `CITD_MASK_LOW
         && op_cycles_ff == 4'h2;
   endproperty
   a_nib: assert property (p_nib) else $error("nibble exchange wrong");
   property p_hold;
      busy && !op_done |=> busy && $stable(op_cycles_ff);
   endproperty
   a_hold: assert property (p_hold) else $error("cycle count changed");
   c_mul: cover property (take && opcode == 8'hA4);
   c_b2b: cover property (op_done && op_valid);
   c_emif: cover property (emif_req_ff);
endmodule // citd_asserts
bind citd_decoder citd_asserts u_citd_asserts (
   .mclk, .sys_rst, .op_valid, .opcode, .op_ready, .bank_sel, .r0_value, .r1_value, .xpage,
   .flash_access_en, .direct_addr, .busy, .op_done, .op_bytes_ff, .op_cycles_ff,
   .use_work_reg_ff, .work_reg_addr_ff, .use_indirect_ff, .indirect_addr_ff, .direct_sfr_ff,
   .xmove_ff, .xmove_wide_ff, .xaddr_ff, .xtarget_ff, .emif_req_ff, .xchg_mask_ff
);

// ==== citd_defines.vh ====
// constants for the instruction length and cycle-timing decoder
`ifndef CITD_DEFINES_VH
`define CITD_DEFINES_VH
// encoded instruction lengths in bytes
`define CITD_LEN_1 2'h1
`define CITD_LEN_2 2'h2
`define CITD_LEN_3 2'h3
// execution times in system clock cycles
`define CITD_CYC_1 4'h1
`define CITD_CYC_2 4'h2
`define CITD_CYC_3 4'h3
`define CITD_CYC_4 4'h4
`define CITD_CYC_8 4'h8
// instruction kinds
`define CITD_K_ARITH 4'h0
`define CITD_K_INCDEC 4'h1
`define CITD_K_DPINC 4'h2
`define CITD_K_MUL 4'h3
`define CITD_K_DIV 4'h4
`define CITD_K_LOGIC 4'h5
`define CITD_K_ACCU 4'h6
`define CITD_K_MOV 4'h7
`define CITD_K_CODE 4'h8
`define CITD_K_XMOVE 4'h9
`define CITD_K_STACK 4'hA
`define CITD_K_ACC_EXCH 4'hB
`define CITD_K_NIBX 4'hC
`define CITD_K_NONE 4'hF
// direct address space split
`define CITD_SFR_BASE 8'h80
// external-data move targets, one-hot
`define CITD_TGT_NONE 3'h0
`define CITD_TGT_RAM 3'h1
`define CITD_TGT_EMIF 3'h2
`define CITD_TGT_FLASH 3'h4
// exchange masks
`define CITD_MASK_LOW 8'h0F
`define CITD_MASK_FULL 8'hFF
// on-chip external-data ram size in bytes
`define CITD_EXT_RAM_BYTES 17'h01000
`endif

// ==== citd_unused_guard.v ====
// spare file: holds no logic

// ==== citd_xtgt.v ====
// address and target selection for the external-data move
`timescale 1ns/1ps
`include "citd_defines.vh"
module citd_xtgt #(
   parameter EMIF_PRESENT = 1,
   parameter [16:0] EXT_RAM_BYTES = `CITD_EXT_RAM_BYTES
) (
   input wire wide,            // data pointer form
   input wire [7:0] ri_val,    // low address from the indirect register
   input wire [7:0] xpage,     // high address for the 8-bit form
   input wire [15:0] data_pointer, // data pointer value
   input wire flash_access_en, // moves go to program flash
   output wire [15:0] xaddr,   // resolved address
   output reg [2:0] target     // one-hot target
);
   assign xaddr = wide ? data_pointer : {xpage, ri_val};

   always @* begin
      if (flash_access_en) begin
         target = `CITD_TGT_FLASH;
      end else if ({1'b0, xaddr} < EXT_RAM_BYTES) begin
         target = `CITD_TGT_RAM;
      end else if (EMIF_PRESENT != 0) begin
         target = `CITD_TGT_EMIF;
      end else begin
         target = `CITD_TGT_RAM; // no interface: on-chip ram aliases
      end
   end
endmodule // citd_xtgt

// ==== test_core_instruction_timing_decoder.sv ====
// self-checking bench for the instruction timing decoder
`timescale 1ns/1ps
`include "citd_defines.vh"
module test_core_instruction_timing_decoder;
// ********
// signals and design
// ********
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic op_valid = 1'b0;
   logic flash_access_en = 1'b0;
   logic [1:0] bank_sel = 2'h0;
   logic [7:0] opcode = 8'h00, r0_value = 8'h00, r1_value = 8'h00;
   logic [7:0] xpage = 8'h12, direct_addr = 8'h00;
   logic [15:0] data_pointer = 16'h0000;
   wire op_ready, busy, op_done, op_legal_ff, use_work_reg_ff, use_indirect_ff, use_direct_ff;
   wire direct_sfr_ff, xmove_ff, xmove_write_ff, xmove_wide_ff, emif_req_ff;
   wire [1:0] op_bytes_ff;
   wire [2:0] xtarget_ff;
   wire [3:0] op_cycles_ff, op_kind_ff;
   wire [4:0] work_reg_addr_ff;
   wire [7:0] indirect_addr_ff, xchg_mask_ff;
   wire [15:0] xaddr_ff;
   int fails = 0;
   int total_checks = 0;
   // opcode, bytes, cycles, kind
   logic [19:0] tbl [0:76] = '{
    20'h28110, 20'h25220, 20'h26120, 20'h24220, 20'h38110, 20'h35220, 20'h36120, 20'h34220,
    20'h98110, 20'h95220, 20'h96120, 20'h94220, 20'h04111, 20'h08111, 20'h05221, 20'h06121,
    20'h14111, 20'h18111, 20'h15221, 20'h16121, 20'hA3112, 20'hA4143, 20'h84184, 20'hD4116,
    20'h58115, 20'h55225, 20'h56125, 20'h54225, 20'h52225, 20'h53335, 20'h48115, 20'h45225,
    20'h46125, 20'h44225, 20'h42225, 20'h43335, 20'h68115, 20'h65225, 20'h66125, 20'h64225,
    20'h62225, 20'h63335, 20'hE4116, 20'hF4116, 20'h23116, 20'h33116, 20'h03116, 20'h13116,
    20'hC4116, 20'hE8117, 20'hE5227, 20'hE6127, 20'h74227, 20'hF8117, 20'hA8227, 20'h78227,
    20'hF5227, 20'h88227, 20'h85337, 20'h86227, 20'h75337, 20'hF6127, 20'hA6227, 20'h76227,
    20'h90337, 20'h93138, 20'h83138, 20'hE0139, 20'hE2139, 20'hF0139, 20'hF2139, 20'hC022A,
    20'hD022A, 20'hC811B, 20'hC522B, 20'hC612B, 20'hD612C};
   logic [7:0] xops [0:3] = '{8'hE0, 8'hF0, 8'hE2, 8'hF3};
   always #50 mclk = ~mclk;
   citd_decoder DUT (
      .mclk, .sys_rst, .op_valid, .opcode, .op_ready, .bank_sel, .r0_value, .r1_value,
      .xpage, .data_pointer, .flash_access_en, .direct_addr, .busy, .op_done, .op_bytes_ff,
      .op_cycles_ff, .op_kind_ff, .op_legal_ff, .use_work_reg_ff, .work_reg_addr_ff,
      .use_indirect_ff, .indirect_addr_ff, .use_direct_ff, .direct_sfr_ff, .xmove_ff,
      .xmove_write_ff, .xmove_wide_ff, .xaddr_ff, .xtarget_ff, .emif_req_ff, .xchg_mask_ff
   );
// ********
// helpers
// ********
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t ns: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // one cycle on, bounded by k
   task automatic step(inout int k);
      @(posedge mclk);
      #1;
      k++;
      if (k > 20) begin
         fails++;
         test_done;
      end
   endtask
   // offer until taken, return in the first execution cycle
   task automatic take(input logic [7:0] op);
      int k;
      k = 0;
      opcode = op;
      op_valid = 1'b1;
      while (op_ready !== 1'b1)
         step(k);
      @(posedge mclk);
      #1;
   endtask
   task automatic finish_op(output int n);
      n = 1;
      while (op_done !== 1'b1)
         step(n);
   endtask
// ********
// scenarios
// ********
   task automatic t_table;
      int n;
      for (int p = 0; p < 2; p++) begin
         {r0_value, r1_value, direct_addr} = p ? 24'hFFC380 : 24'h003C7F;
         for (int i = 0; i < 77; i++) begin
            take(tbl[i][19:12]);
            op_valid = 1'b0;
            chk(op_bytes_ff, tbl[i][11:8]);
            chk(op_cycles_ff, tbl[i][7:4]);
            chk({op_legal_ff, op_kind_ff}, {1'b1, tbl[i][3:0]});
            finish_op(n);
            chk(n, tbl[i][7:4]);
            step(n);
         end
      end
      $display("t_table done");
   endtask
   task automatic t_b2b;
      int n;
      take(8'h84);
      opcode = 8'h28;
      n = 1;
      while (op_done !== 1'b1) begin
         chk(op_ready, 1'b0);
         step(n);
      end
      chk(n, 4'h8);
      chk(op_kind_ff, `CITD_K_DIV);
      step(n);
      op_valid = 1'b0;
      chk({op_kind_ff, op_done, busy}, {`CITD_K_ARITH, 2'h3});
      step(n);
      take(8'hA4);
      op_valid = 1'b0;
      sys_rst = 1'b1;
      step(n);
      sys_rst = 1'b0;
      chk({busy, op_kind_ff, xchg_mask_ff}, {1'b0, `CITD_K_NONE, `CITD_MASK_FULL});
      step(n);
      $display("t_b2b done");
   endtask
   task automatic t_xmove;
      int n;
      logic [7:0] xm;
      logic [15:0] a;
      logic [2:0] t;
      {r0_value, r1_value} = 16'h3456;
      for (int i = 0; i < 4; i++) begin
         xm = xops[i];
         flash_access_en = (i == 3);
         data_pointer = i[0] ? 16'h0FFF : 16'h1000;
         take(xm);
         op_valid = 1'b0;
         a = xm[1] ? {xpage, xm[0] ? r1_value : r0_value} : data_pointer;
         t = (a >= `CITD_EXT_RAM_BYTES) ? `CITD_TGT_EMIF : `CITD_TGT_RAM;
         if (flash_access_en)
            t = `CITD_TGT_FLASH;
         chk({xmove_ff, xmove_wide_ff, xmove_write_ff}, {1'b1, !xm[1], xm[4]});
         chk(xaddr_ff, a);
         chk(xtarget_ff, t);
         chk(emif_req_ff, t == `CITD_TGT_EMIF);
         n = 0;
         step(n);
         chk(emif_req_ff, 1'b0);
         while (op_done !== 1'b1)
            step(n);
         step(n);
      end
      flash_access_en = 1'b0;
      $display("t_xmove done");
   endtask
   task automatic t_operand;
      int n;
      for (int b = 0; b < 32; b++) begin
         n = 0;
         bank_sel = b[4:3];
         take({5'h01, b[2:0]});
         op_valid = 1'b0;
         chk({use_work_reg_ff, work_reg_addr_ff}, {1'b1, b[4:0]});
         step(n);
      end
      {r0_value, r1_value} = 16'h9C63;
      for (int i = 0; i < 2; i++) begin
         take(i ? 8'hC7 : 8'hD6);
         op_valid = 1'b0;
         chk({use_indirect_ff, indirect_addr_ff}, {1'b1, i ? r1_value : r0_value});
         chk(xchg_mask_ff, i ? `CITD_MASK_FULL : `CITD_MASK_LOW);
         finish_op(n);
         step(n);
      end
      take(8'h25);
      op_valid = 1'b0;
      chk({use_direct_ff, use_work_reg_ff}, 2'h2);
      finish_op(n);
      step(n);
      take(8'h00);
      op_valid = 1'b0;
      chk({op_legal_ff, use_direct_ff, op_kind_ff, op_bytes_ff, op_cycles_ff},
          {2'h0, `CITD_K_NONE, `CITD_LEN_1, `CITD_CYC_1});
      step(n);
      for (int i = 0; i < 2; i++) begin
         direct_addr = i ? 8'h80 : 8'h7F;
         step(n);
         chk(direct_sfr_ff, i[0]);
      end
      $display("t_operand done");
   endtask
// ********
// main sequence
// ********
   initial begin
      int n;
      n = 0;
      repeat (5) @(posedge mclk);
      #1;
      sys_rst = 1'b0;
      step(n);
      chk({busy, op_ready, op_kind_ff}, {2'h1, `CITD_K_NONE});
      t_table;
      t_b2b;
      t_xmove;
      t_operand;
      test_done;
   end
endmodule // test_core_instruction_timing_decoder
